// [include/mm_burst_pkg.sv]
package mm_burst_pkg;

	// Default bus geometry; both ends take these as parameter defaults.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int BURST_W = 4;
	// Cycles from the end of the address phase to the sampled read data.
	localparam int FIXED_READ_DELAY = 2;
	// Words of storage behind the slave end.
	localparam int MEM_DEPTH = 256;
	// Entries of the write buffer in front of the storage.
	localparam int WBUF_DEPTH = 2;
	// Burst parameters held for the whole burst when set.
	localparam bit HOLD_BURST_PARAMS = 1'b0;
	// Reset values of the remaining-transfer counters.
	localparam logic [BURST_W-1:0] REMAIN_RST = 4'h0;

	typedef enum logic [2:0] {
		SLV_IDLE = 3'b001,
		SLV_WBURST = 3'b010,
		SLV_RBURST = 3'b100
	} slv_state_t;

	typedef enum logic [2:0] {
		MST_IDLE = 3'b001,
		MST_WRITE = 3'b010,
		MST_READ = 3'b100
	} mst_state_t;

	// A length of zero is illegal on the bus; both ends treat it as one.
	function automatic logic [BURST_W-1:0] eff_len(
		input logic [BURST_W-1:0] len
	);
		eff_len = (len == '0) ? BURST_W'(1) : len;
	endfunction

endpackage

// [include/mm_burst_if.sv]
`timescale 1ns/1ps
interface mm_burst_if #(
	parameter int ADDR_W = mm_burst_pkg::ADDR_W,
	parameter int DATA_W = mm_burst_pkg::DATA_W,
	parameter int BURST_W = mm_burst_pkg::BURST_W
);
	logic [ADDR_W-1:0] address;
	logic [BURST_W-1:0] burst_len;
	logic read;
	logic write;
	logic [DATA_W-1:0] writedata;
	logic [DATA_W/8-1:0] lane_sel;
	logic begin_burst;
	logic stall;
	logic [DATA_W-1:0] readdata;
	logic readdata_valid;

	modport slave_end (
		input address, burst_len, read, write, writedata, lane_sel,
		input begin_burst,
		output stall, readdata, readdata_valid
	);

	modport master_end (
		output address, burst_len, read, write, writedata, lane_sel,
		output begin_burst,
		input stall, readdata, readdata_valid
	);
endinterface

// [rtl/mm_burst_master.sv]
`timescale 1ns/1ps
module mm_burst_master #(
	parameter int ADDR_W = mm_burst_pkg::ADDR_W,
	parameter int DATA_W = mm_burst_pkg::DATA_W,
	parameter int BURST_W = mm_burst_pkg::BURST_W,
	parameter bit HOLD_BURST_PARAMS = mm_burst_pkg::HOLD_BURST_PARAMS
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	mm_burst_if.master_end bus,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [ADDR_W-1:0] i_cmd_addr,
	input wire logic [BURST_W-1:0] i_cmd_len,
	output logic o_cmd_ready,
	input wire logic i_wr_valid,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic [DATA_W/8-1:0] i_wr_lanes,
	output logic o_wr_ready,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_rd_valid
);
	localparam int LANE_W = DATA_W / 8;

	mm_burst_pkg::mst_state_t state, next_state;
	logic [ADDR_W-1:0] address, next_address;
	logic [BURST_W-1:0] burst_len, next_burst_len;
	logic [BURST_W-1:0] remain, next_remain;
	logic read, next_read;
	logic write, next_write;
	logic [DATA_W-1:0] writedata, next_writedata;
	logic [LANE_W-1:0] lane_sel, next_lane_sel;
	logic begin_burst, next_begin_burst;
	logic word_go;
	logic [DATA_W-1:0] rd_data, next_rd_data;
	logic rd_valid, next_rd_valid;

	// A write word leaves only on a cycle the slave does not stall.
	assign word_go = write & ~bus.stall;

	// Handshakes toward the user side are combinational.
	always_comb begin
		o_cmd_ready = (state == mm_burst_pkg::MST_IDLE) &&
			(!i_cmd_write || i_wr_valid);
		o_wr_ready = 1'b0;
		if (state == mm_burst_pkg::MST_IDLE) begin
			o_wr_ready = i_cmd_valid & i_cmd_write;
		end else if (state == mm_burst_pkg::MST_WRITE) begin
			o_wr_ready = !write || (word_go && remain != BURST_W'(1));
		end
	end

	// Command sequencing; bus outputs all come from flip-flops.
	always_comb begin
		next_state = state;
		next_address = address;
		next_burst_len = burst_len;
		next_remain = remain;
		next_read = read;
		next_write = write;
		next_writedata = writedata;
		next_lane_sel = lane_sel;
		next_begin_burst = 1'b0;
		case (state)
		mm_burst_pkg::MST_IDLE: begin
			if (i_cmd_valid && o_cmd_ready) begin
				next_address = i_cmd_addr;
				next_burst_len = mm_burst_pkg::eff_len(i_cmd_len);
				next_remain = mm_burst_pkg::eff_len(i_cmd_len);
				next_begin_burst = 1'b1;
				if (i_cmd_write) begin
					next_write = 1'b1;
					next_writedata = i_wr_data;
					next_lane_sel = i_wr_lanes;
					next_state = mm_burst_pkg::MST_WRITE;
				end else begin
					next_read = 1'b1;
					next_state = mm_burst_pkg::MST_READ;
				end
			end
		end
		mm_burst_pkg::MST_WRITE: begin
			if (word_go) begin
				next_remain = remain - BURST_W'(1);
				if (!HOLD_BURST_PARAMS) begin
					// Parameters are only meaningful on the first word.
					next_address = '0;
					next_burst_len = '0;
				end
				if (remain == BURST_W'(1)) begin
					next_write = 1'b0;
					next_state = mm_burst_pkg::MST_IDLE;
				end else begin
					next_write = i_wr_valid;
					next_writedata = i_wr_data;
					next_lane_sel = i_wr_lanes;
				end
			end else if (!write && i_wr_valid) begin
				next_write = 1'b1;
				next_writedata = i_wr_data;
				next_lane_sel = i_wr_lanes;
			end
		end
		mm_burst_pkg::MST_READ: begin
			// Returning to idle at once lets reads overlap their data.
			if (!bus.stall) begin
				next_read = 1'b0;
				next_state = mm_burst_pkg::MST_IDLE;
			end
		end
		default: begin
			next_state = mm_burst_pkg::MST_IDLE;
			next_read = 1'b0;
			next_write = 1'b0;
		end
		endcase
		next_rd_valid = bus.readdata_valid;
		next_rd_data = bus.readdata_valid ? bus.readdata : rd_data;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= mm_burst_pkg::MST_IDLE;
			address <= '0;
			burst_len <= '0;
			remain <= mm_burst_pkg::REMAIN_RST;
			read <= 1'b0;
			write <= 1'b0;
			writedata <= '0;
			lane_sel <= '0;
			begin_burst <= 1'b0;
			rd_data <= '0;
			rd_valid <= 1'b0;
		end else begin
			state <= next_state;
			address <= next_address;
			burst_len <= next_burst_len;
			remain <= next_remain;
			read <= next_read;
			write <= next_write;
			writedata <= next_writedata;
			lane_sel <= next_lane_sel;
			begin_burst <= next_begin_burst;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	assign bus.address = address;
	assign bus.burst_len = burst_len;
	assign bus.read = read;
	assign bus.write = write;
	assign bus.writedata = writedata;
	assign bus.lane_sel = lane_sel;
	assign bus.begin_burst = begin_burst;
	assign o_rd_data = rd_data;
	assign o_rd_valid = rd_valid;
endmodule // mm_burst_master

// [rtl/mm_burst_slave.sv]
// Functional notes
// - Read data returns a fixed delay later.
// - Stall may stretch the address phase.
// - Data sampled on nth edge after acceptance.
// - Overlapping reads each keep fixed latency.
// - Arbitration stays locked for whole burst.
// - Bursts supported for both reads and writes.
// - Burst length input marks burst capability.
// - Burst length ranges one to half range.
// - Read bursts need stall and valid qualifier.
// - Burst does b transfers from address a.
// - Address and length latched once per burst.
// - First-cycle marker lasts exactly one cycle.
// - Write burst takes exactly n data words.
// - Dropped write pauses burst, stores nothing.
// - Master holds signals while slave stalls.
// - Lane selects may vary word to word.
// - All-lanes-off write still counts as transfer.
// - Held parameters stay stable through burst.
// - Otherwise parameters sampled on first transfer.
// - Read words qualified one cycle each.
// - Read data returns in command order.
`timescale 1ns/1ps
module mm_burst_slave #(
	parameter int ADDR_W = mm_burst_pkg::ADDR_W,
	parameter int DATA_W = mm_burst_pkg::DATA_W,
	parameter int BURST_W = mm_burst_pkg::BURST_W,
	parameter int FIXED_READ_DELAY = mm_burst_pkg::FIXED_READ_DELAY,
	parameter int MEM_DEPTH = mm_burst_pkg::MEM_DEPTH
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	mm_burst_if.slave_end bus,
	input wire logic i_mem_ready,
	output logic o_burst_end,
	output logic o_wbuf_full
);
	localparam int LANE_W = DATA_W / 8;
	localparam int MEM_AW = $clog2(MEM_DEPTH);
	localparam int STG = (FIXED_READ_DELAY > 1) ? FIXED_READ_DELAY - 1 : 1;
	localparam int TAP = (FIXED_READ_DELAY > 1) ? FIXED_READ_DELAY - 2 : 0;
	localparam int BUF_N = mm_burst_pkg::WBUF_DEPTH;
	localparam int BUF_AW = (BUF_N > 1) ? $clog2(BUF_N) : 1;

	mm_burst_pkg::slv_state_t state, next_state;
	logic [ADDR_W-1:0] burst_addr, next_burst_addr;
	logic [BURST_W-1:0] remain, next_remain;
	logic burst_end, next_burst_end;
	logic rd_accept, wr_accept, stall;
	logic issue_v;
	logic [ADDR_W-1:0] issue_a;
	logic stg_v [STG];
	logic [ADDR_W-1:0] stg_a [STG];
	logic next_stg_v [STG];
	logic [ADDR_W-1:0] next_stg_a [STG];
	logic tap_v;
	logic [ADDR_W-1:0] tap_a;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic rvalid, next_rvalid;
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [ADDR_W-1:0] buf_addr [BUF_N];
	logic [DATA_W-1:0] buf_data [BUF_N];
	logic [LANE_W-1:0] buf_lanes [BUF_N];
	logic [BUF_AW-1:0] buf_wp, next_buf_wp, buf_rp, next_buf_rp;
	logic [BUF_AW:0] buf_cnt, next_buf_cnt;
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
	logic [ADDR_W-1:0] push_addr;

	// Advance a pointer around the write buffer.
	function automatic logic [BUF_AW-1:0] buf_inc(
		input logic [BUF_AW-1:0] p
	);
		buf_inc = (p == BUF_AW'(BUF_N - 1)) ? '0 : p + BUF_AW'(1);
	endfunction

	// Storage index of a bus word address.
	function automatic logic [MEM_AW-1:0] mem_idx(
		input logic [ADDR_W-1:0] a
	);
		mem_idx = a[MEM_AW-1:0];
	endfunction

	// Stall covers three hazards: an internal read burst owns the
	// pipeline, a read must not overtake buffered writes, and a full
	// buffer cannot take another word. Reads wait rather than snoop.
	always_comb begin
		buf_in_ready = (buf_cnt != (BUF_AW+1)'(BUF_N));
		stall = ((state == mm_burst_pkg::SLV_RBURST) &
			(bus.read | bus.write)) |
			(bus.read & (buf_cnt != '0)) |
			(bus.write & ~buf_in_ready);
		rd_accept = bus.read & ~stall &
			(state == mm_burst_pkg::SLV_IDLE);
		// Every unstalled write is a word, even with all lanes off.
		wr_accept = bus.write & ~stall &
			(state != mm_burst_pkg::SLV_RBURST);
	end

	// Burst sequencing: parameters are taken only on the first
	// transfer; later addresses come from the local counter.
	always_comb begin
		next_state = state;
		next_burst_addr = burst_addr;
		next_remain = remain;
		next_burst_end = 1'b0;
		case (state)
		mm_burst_pkg::SLV_IDLE: begin
			if (rd_accept || wr_accept) begin
				next_burst_addr = bus.address + ADDR_W'(1);
				next_remain = mm_burst_pkg::eff_len(bus.burst_len) -
					BURST_W'(1);
				if (mm_burst_pkg::eff_len(bus.burst_len) == BURST_W'(1)) begin
					next_burst_end = 1'b1;
				end else if (rd_accept) begin
					next_state = mm_burst_pkg::SLV_RBURST;
				end else begin
					next_state = mm_burst_pkg::SLV_WBURST;
				end
			end
		end
		mm_burst_pkg::SLV_WBURST: begin
			// Stays here while write is low: a gap is only a pause.
			if (wr_accept) begin
				next_burst_addr = burst_addr + ADDR_W'(1);
				next_remain = remain - BURST_W'(1);
				if (remain == BURST_W'(1)) begin
					next_burst_end = 1'b1;
					next_state = mm_burst_pkg::SLV_IDLE;
				end
			end
		end
		mm_burst_pkg::SLV_RBURST: begin
			// One inferred read enters the pipeline per cycle.
			next_burst_addr = burst_addr + ADDR_W'(1);
			next_remain = remain - BURST_W'(1);
			if (remain == BURST_W'(1)) begin
				next_burst_end = 1'b1;
				next_state = mm_burst_pkg::SLV_IDLE;
			end
		end
		default: begin
			next_state = mm_burst_pkg::SLV_IDLE;
		end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= mm_burst_pkg::SLV_IDLE;
			burst_addr <= '0;
			remain <= mm_burst_pkg::REMAIN_RST;
			burst_end <= 1'b0;
		end else begin
			state <= next_state;
			burst_addr <= next_burst_addr;
			remain <= next_remain;
			burst_end <= next_burst_end;
		end
	end

	// Read pipeline. A shift line of fixed length keeps every read,
	// overlapped or inferred, at the same delay and in order.
	always_comb begin
		issue_v = rd_accept | (state == mm_burst_pkg::SLV_RBURST);
		issue_a = (state == mm_burst_pkg::SLV_RBURST) ? burst_addr :
			bus.address;
		next_stg_v[0] = issue_v;
		next_stg_a[0] = issue_a;
		for (int k = 1; k < STG; k++) begin
			next_stg_v[k] = stg_v[k-1];
			next_stg_a[k] = stg_a[k-1];
		end
		tap_v = (FIXED_READ_DELAY > 1) ? stg_v[TAP] : issue_v;
		tap_a = (FIXED_READ_DELAY > 1) ? stg_a[TAP] : issue_a;
		next_rvalid = tap_v;
		next_rdata = tap_v ? mem[mem_idx(tap_a)] : rdata;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			for (int k = 0; k < STG; k++) begin
				stg_v[k] <= 1'b0;
				stg_a[k] <= '0;
			end
			rvalid <= 1'b0;
			rdata <= '0;
		end else begin
			for (int k = 0; k < STG; k++) begin
				stg_v[k] <= next_stg_v[k];
				stg_a[k] <= next_stg_a[k];
			end
			rvalid <= next_rvalid;
			rdata <= next_rdata;
		end
	end

	// Write buffer between the bus and storage. When storage is busy
	// it fills, and a full buffer raises stall toward the master.
	always_comb begin
		buf_in_valid = wr_accept;
		buf_out_valid = (buf_cnt != '0);
		buf_out_ready = i_mem_ready;
		push_addr = (state == mm_burst_pkg::SLV_WBURST) ? burst_addr :
			bus.address;
		next_buf_wp = buf_wp;
		next_buf_rp = buf_rp;
		next_buf_cnt = buf_cnt;
		if (buf_in_valid && buf_in_ready) begin
			next_buf_wp = buf_inc(buf_wp);
		end
		if (buf_out_valid && buf_out_ready) begin
			next_buf_rp = buf_inc(buf_rp);
		end
		if ((buf_in_valid && buf_in_ready) &&
			!(buf_out_valid && buf_out_ready)) begin
			next_buf_cnt = buf_cnt + (BUF_AW+1)'(1);
		end else if (!(buf_in_valid && buf_in_ready) &&
			(buf_out_valid && buf_out_ready)) begin
			next_buf_cnt = buf_cnt - (BUF_AW+1)'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			buf_wp <= '0;
			buf_rp <= '0;
			buf_cnt <= '0;
		end else begin
			buf_wp <= next_buf_wp;
			buf_rp <= next_buf_rp;
			buf_cnt <= next_buf_cnt;
		end
	end

	// Buffer slots and storage hold data only, so they carry no reset.
	always_ff @(posedge i_core_clk) begin
		if (buf_in_valid && buf_in_ready) begin
			buf_addr[buf_wp] <= push_addr;
			buf_data[buf_wp] <= bus.writedata;
			buf_lanes[buf_wp] <= bus.lane_sel;
		end
		if (buf_out_valid && buf_out_ready) begin
			for (int b = 0; b < LANE_W; b++) begin
				if (buf_lanes[buf_rp][b]) begin
					mem[mem_idx(buf_addr[buf_rp])][8*b +: 8] <=
						buf_data[buf_rp][8*b +: 8];
				end
			end
		end
	end

	assign bus.stall = stall;
	assign bus.readdata = rdata;
	assign bus.readdata_valid = rvalid;
	assign o_burst_end = burst_end;
	assign o_wbuf_full = ~buf_in_ready;
endmodule // mm_burst_slave

// [sim/mm_slave_fixed_latency_burst_assertions.sv]
`timescale 1ns/1ps
// Watches the bus between the two ends; nothing is checked during reset.
module mm_slave_fixed_latency_burst_assertions #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 32,
	parameter int BURST_W = 4,
	parameter int FIXED_READ_DELAY = 2
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [BURST_W-1:0] burst_len,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	input wire logic [DATA_W/8-1:0] lane_sel,
	input wire logic begin_burst,
	input wire logic stall,
	input wire logic [DATA_W-1:0] readdata,
	input wire logic readdata_valid
);
	logic rd_take;

	// A read is taken at an edge where it is requested and not stalled.
	assign rd_take = read && !stall;

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// A held write word must not move until the slave lets it through.
	sequence wr_held;
		write && stall;
	endsequence
	sequence wr_kept;
		write && $stable(writedata) && $stable(lane_sel) && $stable(burst_len);
	endsequence

	a_read_fixed_delay: assert property (
		rd_take |-> ##FIXED_READ_DELAY readdata_valid)
		else $error("read word not returned at the fixed delay");
	a_valid_has_cause: assert property (
		readdata_valid |-> $past(rd_take, FIXED_READ_DELAY) ||
			$past(readdata_valid))
		else $error("read word returned without a taken read");
	a_read_stall_hold: assert property (read && stall |=> read)
		else $error("stalled read dropped");
	a_write_stall_hold: assert property (wr_held |=> wr_kept)
		else $error("stalled write word changed");
	a_begin_one_cycle: assert property (begin_burst |=> !begin_burst)
		else $error("burst start marker longer than one cycle");
	a_begin_with_cmd: assert property (begin_burst |-> read || write)
		else $error("burst start marker without a command");
	a_idle_no_stall: assert property (!read && !write |-> !stall)
		else $error("stall raised with no request");
	a_one_command: assert property (!(read && write))
		else $error("read and write requested together");
endmodule // mm_slave_fixed_latency_burst_assertions

// [sim/mm_slave_fixed_latency_burst_bench.sv]
`timescale 1ns/1ps
// Random bursts through the master end, read back and compared.
module mm_slave_fixed_latency_burst_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [15:0] cmd_addr = 16'h0000;
	logic [3:0] cmd_len = 4'h1;
	logic wr_valid = 1'b0;
	logic [31:0] wr_data = 32'h0000_0000;
	logic [3:0] wr_lanes = 4'hf;
	logic mem_ready = 1'b1;
	logic mem_hold = 1'b0;
	logic cmd_ready, wr_ready, rd_valid, burst_end, wbuf_full;
	logic [31:0] rd_data;
	logic [31:0] exp_mem [256];
	logic [31:0] exp_q [$];
	int fail_count = 0;
	int samples_checked = 0;
	int cmd_count = 0;
	int end_count = 0;
	bit full_seen = 1'b0;

	mm_burst_if bus_if ();
	mm_burst_master mm_burst_master_inst (.i_core_clk(core_clk),
		.i_rst(rst), .bus(bus_if), .i_cmd_valid(cmd_valid),
		.i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len),
		.o_cmd_ready(cmd_ready), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
		.i_wr_lanes(wr_lanes), .o_wr_ready(wr_ready), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid));
	mm_burst_slave mm_burst_slave_inst (.i_core_clk(core_clk), .i_rst(rst),
		.bus(bus_if), .i_mem_ready(mem_ready), .o_burst_end(burst_end),
		.o_wbuf_full(wbuf_full));
	mm_slave_fixed_latency_burst_assertions assertions_inst (
		.i_core_clk(core_clk), .i_rst(rst), .address(bus_if.address),
		.burst_len(bus_if.burst_len), .read(bus_if.read),
		.write(bus_if.write), .writedata(bus_if.writedata),
		.lane_sel(bus_if.lane_sel), .begin_burst(bus_if.begin_burst),
		.stall(bus_if.stall), .readdata(bus_if.readdata),
		.readdata_valid(bus_if.readdata_valid));

	// Free-running core clock.
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input bit ok, input string msg);
		samples_checked++;
		if (!ok) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic stop_test;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Byte lanes that are off keep the old content.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] lanes);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (lanes[b]) r[8*b+:8] = nw[8*b+:8];
		return r;
	endfunction

	// Ready is combinational, so it is judged at the falling edge where it
	// has settled; the rising edge that follows takes the request.
	task automatic wait_ready(input bit for_cmd);
		int t;
		t = 0;
		do begin
			@(negedge core_clk);
			t++;
		end while ((for_cmd ? cmd_ready : wr_ready) !== 1'b1 && t < 300);
		check(t < 300, "handshake never completed");
	endtask

	task automatic run_cmd(input bit wr, input logic [15:0] a,
		input logic [3:0] n, input bit gaps);
		int len;
		len = (n == 4'h0) ? 1 : int'(n);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr <= a;
		cmd_len <= n;
		for (int k = 0; k < (wr ? len : 1); k++) begin
			if (wr) begin
				if (gaps && k > 0 && $urandom_range(3) == 0) begin
					wr_valid <= 1'b0;
					@(posedge core_clk);
				end
				wr_valid <= 1'b1;
				wr_data <= $urandom;
				wr_lanes <= gaps ? ((k == 1) ? 4'h0 : 4'($urandom)) : 4'hf;
			end
			wait_ready(k == 0);
			@(posedge core_clk);
			if (wr) exp_mem[8'(a + k)] = merge(exp_mem[8'(a + k)], wr_data,
				wr_lanes);
			cmd_valid <= 1'b0;
		end
		wr_valid <= 1'b0;
		if (!wr)
			for (int k = 0; k < len; k++) exp_q.push_back(exp_mem[8'(a + k)]);
		cmd_count++;
	endtask

	// Storage readiness is random, and returned words are compared in order.
	always @(posedge core_clk) begin
		mem_ready <= !mem_hold && ($urandom_range(3) != 0);
		if (!rst && wbuf_full === 1'b1) full_seen = 1'b1;
		if (!rst && burst_end === 1'b1) end_count++;
		if (!rst && rd_valid === 1'b1) begin
			if (exp_q.size() == 0) check(1'b0, "unexpected read word");
			else check(rd_data === exp_q.pop_front(), "read word wrong");
		end
	end

	// Cuts a hang short; the whole run needs well under a thousand cycles.
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		stop_test;
	end

	initial begin
		logic [15:0] a;
		logic [3:0] n;
		void'($urandom(32'hd28b));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		// Fill words 0 to 63 with longest bursts so no read sees unknowns.
		for (int i = 0; i < 8; i++) run_cmd(1'b1, 16'(i * 8), 4'h8, 1'b0);
		// Back-to-back single reads, then a longest read burst.
		for (int i = 0; i < 6; i++) run_cmd(1'b0, 16'(i), 4'h1, 1'b0);
		run_cmd(1'b0, 16'h0008, 4'h8, 1'b0);
		// Writes with pauses and partial lanes; one extra word read back
		// shows that a burst wrote no more than its length.
		repeat (30) begin
			a = 16'($urandom_range(55));
			n = 4'($urandom_range(7, 1));
			run_cmd(1'b1, a, n, 1'b1);
			run_cmd(1'b0, a, 4'(n + 1), 1'b0);
		end
		// Starve storage so the buffer fills and writes stall.
		mem_hold <= 1'b1;
		fork
			run_cmd(1'b1, 16'h0010, 4'h8, 1'b0);
			begin
				repeat (20) @(posedge core_clk);
				mem_hold <= 1'b0;
			end
		join
		run_cmd(1'b0, 16'h0010, 4'h8, 1'b0);
		for (int t = 0; t < 50 && exp_q.size() != 0; t++) @(posedge core_clk);
		repeat (4) @(posedge core_clk);
		check(exp_q.size() == 0, "read words missing");
		check(end_count == cmd_count, "burst end count wrong");
		check(full_seen, "write buffer never filled");
		stop_test;
	end
endmodule // mm_slave_fixed_latency_burst_bench
